// ---- hdl/timer_pkg.sv ----
package timer_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register addresses in special function register space
	localparam logic [7:0] CTRL_ADDR    = 8'h88;
	localparam logic [7:0] MODE_ADDR    = 8'h89;
	localparam logic [7:0] LOW_ADDR [2] = '{8'h8A, 8'h8B};
	localparam logic [7:0] HIGH_ADDR[2] = '{8'h8C, 8'h8D};
	localparam logic [7:0] EXT_CFG_ADDR = 8'hE4;

	////////////////////////////////////////////////////////////////////////////
	// Control register fields; timer 1 and input 1 sit one stride above
	localparam int TF0_BIT     = 5;
	localparam int TR0_BIT     = 4;
	localparam int IE0_BIT     = 1;
	localparam int IT0_BIT     = 0;
	localparam int CTRL_STRIDE = 2;

	// Mode register fields; timer 1 sits one stride above timer 0
	localparam int MODE_LSB    = 0;
	localparam int GATE_BIT    = 3;
	localparam int MODE_STRIDE = 4;

	// External input configuration: polarity of input i at bit i
	localparam int POL0_BIT    = 0;

	////////////////////////////////////////////////////////////////////////////
	// Reset values and count limits
	localparam logic [7:0]  CTRL_RESET    = 8'h00;
	localparam logic [7:0]  MODE_RESET    = 8'h00;
	localparam logic [7:0]  BYTE_RESET    = 8'h00;
	localparam logic [1:0]  POL_RESET     = 2'h0;
	localparam logic [7:0]  BYTE_ALL_ONES = 8'hFF;
	localparam logic [15:0] WORD_ALL_ONES = 16'hFFFF;

	// Counting modes, in field encoding order
	typedef enum logic [1:0] {
		MODE_BASIC,
		MODE_16BIT,
		MODE_RELOAD,
		MODE_SPARE
	} timer_mode_e;

endpackage : timer_pkg

// ---- hdl/timer_lane_if.sv ----
`timescale 1ns/1ps
interface timer_lane_if;
	import timer_pkg::*;

	timer_mode_e mode;
	logic        gate;
	logic        run;
	logic        ext_active;
	logic        wr_low;
	logic        wr_high;
	logic [7:0]  wdata;
	logic [7:0]  low;
	logic [7:0]  high;
	logic        overflow;

	modport lane (input mode, gate, run, ext_active, wr_low, wr_high, wdata,
		output low, high, overflow);
	modport ctrl (output mode, gate, run, ext_active, wr_low, wr_high, wdata,
		input low, high, overflow);

endinterface : timer_lane_if

// ---- hdl/timer_lane.sv ----
`timescale 1ns/1ps
module timer_lane
	import timer_pkg::*;
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic reset_i,
	// Controls and count bytes
	timer_lane_if.lane lane
);

	logic [7:0] low;
	logic [7:0] high;
	logic [7:0] next_low;
	logic [7:0] next_high;
	logic       next_ovf;
	logic       count_en;

	////////////////////////////////////////////////////////////////////////////
	// Next count; a software byte write overrides the count in that cycle
	always_comb begin
		next_low  = low;
		next_high = high;
		next_ovf  = 1'b0;
		count_en  = lane.run && (!lane.gate || lane.ext_active);
		if (count_en) begin
			if (lane.mode == MODE_RELOAD) begin
				if (low == BYTE_ALL_ONES) begin
					next_low = high;
					next_ovf = 1'b1;
				end else begin
					next_low = low + 8'h01;
				end
			end else begin
				{next_high, next_low} = {high, low} + 16'h0001;
				next_ovf = ({high, low} == WORD_ALL_ONES);
			end
		end
		if (lane.wr_low) begin
			next_low = lane.wdata;
		end
		if (lane.wr_high) begin
			next_high = lane.wdata;
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			low  <= BYTE_RESET;
			high <= BYTE_RESET;
		end else begin
			low  <= next_low;
			high <= next_high;
		end
	end

	// Overflow leaves combinationally so the flag lands on the rollover edge
	assign lane.low      = low;
	assign lane.high     = high;
	assign lane.overflow = next_ovf;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (reset_i);

	sequence reload_roll_s;
		count_en && lane.mode == MODE_RELOAD && low == BYTE_ALL_ONES
			&& !lane.wr_low && !lane.wr_high;
	endsequence

	sequence reloaded_s;
		low == $past(high) && high == $past(high);
	endsequence

	reload_keeps_high_a: assert property (
		reload_roll_s |=> reloaded_s)
		else $error("reload byte not copied or not kept");

	stopped_holds_a: assert property (
		!count_en && !lane.wr_low && !lane.wr_high |=> $stable(low) && $stable(high))
		else $error("count moved while disabled");

	wide_count_a: assert property (
		count_en && lane.mode == MODE_16BIT && !lane.wr_low && !lane.wr_high
			|=> {high, low} == $past({high, low}) + 16'h0001)
		else $error("16-bit count did not advance by one");

endmodule : timer_lane

// ---- hdl/dual_timer_top.sv ----
`timescale 1ns/1ps
module dual_timer_top
	import timer_pkg::*;
(
	// Clock and reset
	input  wire logic       clock_i,
	input  wire logic       reset_i,
	// Special function register access
	input  wire logic [7:0] sfr_addr_i,
	input  wire logic [7:0] sfr_wdata_i,
	input  wire logic       sfr_wr_i,
	output logic      [7:0] sfr_rdata_o,
	// CPU interrupt logic
	input  wire logic [1:0] timer_irq_enable_i,
	input  wire logic [1:0] timer_vector_ack_i,
	input  wire logic [1:0] ext_vector_ack_i,
	output logic            timer0_irq_o,
	output logic            timer1_irq_o,
	output logic            ext_irq0_o,
	output logic            ext_irq1_o,
	// External interrupt pins
	input  wire logic       ext_irq_input_0_i,
	input  wire logic       ext_irq_input_1_i
);

	logic [7:0] ctrl;
	logic [7:0] next_ctrl;
	logic [7:0] mode_reg;
	logic [7:0] next_mode_reg;
	logic [1:0] pol;
	logic [1:0] next_pol;
	logic [1:0] sync_a;
	logic [1:0] sync_b;
	logic [1:0] prev_active;
	logic [1:0] active;
	logic [1:0] rise;
	logic [1:0] lane_ovf;
	logic [7:0] lane_low [2];
	logic [7:0] lane_high[2];
	logic [7:0] next_rdata;
	logic [3:0] next_irq;
	logic       ctrl_wr;

	// Address match for one register address
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
		return addr == target;
	endfunction : hit

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; only the second stage is ever looked at
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			// Idle level of active-low pins, so no false active level after reset
			sync_a      <= 2'h3;
			sync_b      <= 2'h3;
			prev_active <= 2'h0;
		end else begin
			sync_a      <= {ext_irq_input_1_i, ext_irq_input_0_i};
			sync_b      <= sync_a;
			prev_active <= active;
		end
	end

	// Active level follows polarity: one means active high
	assign active  = ~(sync_b ^ pol);
	assign rise    = active & ~prev_active;
	assign ctrl_wr = sfr_wr_i && hit(sfr_addr_i, CTRL_ADDR);

	////////////////////////////////////////////////////////////////////////////
	// Timer lanes, one per timer
	timer_lane_if lane_bus[2] ();

	for (genvar i = 0; i < 2; i++) begin : g_lane
		assign lane_bus[i].mode       = timer_mode_e'(mode_reg[i*MODE_STRIDE+MODE_LSB +: 2]);
		assign lane_bus[i].gate       = mode_reg[i*MODE_STRIDE+GATE_BIT];
		assign lane_bus[i].run        = ctrl[TR0_BIT+i*CTRL_STRIDE];
		assign lane_bus[i].ext_active = active[i];
		assign lane_bus[i].wr_low     = sfr_wr_i && hit(sfr_addr_i, LOW_ADDR[i]);
		assign lane_bus[i].wr_high    = sfr_wr_i && hit(sfr_addr_i, HIGH_ADDR[i]);
		assign lane_bus[i].wdata      = sfr_wdata_i;
		assign lane_ovf[i]            = lane_bus[i].overflow;
		assign lane_low[i]            = lane_bus[i].low;
		assign lane_high[i]           = lane_bus[i].high;

		timer_lane u_lane (
			.clock_i (clock_i),
			.reset_i (reset_i),
			.lane    (lane_bus[i])
		);
	end

	////////////////////////////////////////////////////////////////////////////
	// Control, mode and polarity next values; hardware sets win over clears
	always_comb begin
		next_ctrl     = ctrl;
		next_mode_reg = mode_reg;
		next_pol      = pol;
		if (ctrl_wr) begin
			next_ctrl = sfr_wdata_i;
		end
		if (sfr_wr_i && hit(sfr_addr_i, MODE_ADDR)) begin
			next_mode_reg = sfr_wdata_i;
		end
		if (sfr_wr_i && hit(sfr_addr_i, EXT_CFG_ADDR)) begin
			next_pol = sfr_wdata_i[POL0_BIT +: 2];
		end
		for (int i = 0; i < 2; i++) begin
			// Vector acknowledge clears first, so a same-cycle event still sets
			if (timer_vector_ack_i[i]) begin
				next_ctrl[TF0_BIT+i*CTRL_STRIDE] = 1'b0;
			end
			if (lane_ovf[i]) begin
				next_ctrl[TF0_BIT+i*CTRL_STRIDE] = 1'b1;
			end
			if (ctrl[IT0_BIT+i*CTRL_STRIDE]) begin
				if (ext_vector_ack_i[i]) begin
					next_ctrl[IE0_BIT+i*CTRL_STRIDE] = 1'b0;
				end
				if (rise[i]) begin
					next_ctrl[IE0_BIT+i*CTRL_STRIDE] = 1'b1;
				end
			end else begin
				// Level mode mirrors the input; software writes do not stick
				next_ctrl[IE0_BIT+i*CTRL_STRIDE] = active[i];
			end
		end
	end

	// Requests track the flags on the same edge that the flags change
	always_comb begin
		next_irq[0] = next_ctrl[TF0_BIT] && timer_irq_enable_i[0];
		next_irq[1] = next_ctrl[TF0_BIT+CTRL_STRIDE] && timer_irq_enable_i[1];
		next_irq[2] = next_ctrl[IE0_BIT];
		next_irq[3] = next_ctrl[IE0_BIT+CTRL_STRIDE];
	end

	// Read data; unmapped addresses read zero
	always_comb begin
		case (sfr_addr_i)
			CTRL_ADDR:    next_rdata = ctrl;
			MODE_ADDR:    next_rdata = mode_reg;
			LOW_ADDR[0]:  next_rdata = lane_low[0];
			LOW_ADDR[1]:  next_rdata = lane_low[1];
			HIGH_ADDR[0]: next_rdata = lane_high[0];
			HIGH_ADDR[1]: next_rdata = lane_high[1];
			EXT_CFG_ADDR: next_rdata = {6'h00, pol};
			default:      next_rdata = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			ctrl         <= CTRL_RESET;
			mode_reg     <= MODE_RESET;
			pol          <= POL_RESET;
			sfr_rdata_o  <= 8'h00;
			timer0_irq_o <= 1'b0;
			timer1_irq_o <= 1'b0;
			ext_irq0_o   <= 1'b0;
			ext_irq1_o   <= 1'b0;
		end else begin
			ctrl         <= next_ctrl;
			mode_reg     <= next_mode_reg;
			pol          <= next_pol;
			sfr_rdata_o  <= next_rdata;
			timer0_irq_o <= next_irq[0];
			timer1_irq_o <= next_irq[1];
			ext_irq0_o   <= next_irq[2];
			ext_irq1_o   <= next_irq[3];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (reset_i);

	sequence t0_reload_roll_s;
		ctrl[TR0_BIT] && !mode_reg[GATE_BIT] && lane_bus[0].mode == MODE_RELOAD
			&& lane_low[0] == BYTE_ALL_ONES && !lane_bus[0].wr_low;
	endsequence

	sequence t0_flag_and_reload_s;
		ctrl[TF0_BIT] && lane_low[0] == $past(lane_high[0]);
	endsequence

	reload_same_edge_a: assert property (
		t0_reload_roll_s |=> t0_flag_and_reload_s)
		else $error("timer 0 flag and reload not on rollover edge");

	t1_flag_set_a: assert property (
		lane_ovf[1] |=> ctrl[TF0_BIT+CTRL_STRIDE])
		else $error("timer 1 overflow flag not set");

	timer_request_a: assert property (
		timer0_irq_o == (ctrl[TF0_BIT] && $past(timer_irq_enable_i[0])))
		else $error("timer 0 request does not follow flag and enable");

	vector_clear_a: assert property (
		timer_vector_ack_i[0] && !lane_ovf[0] && !ctrl_wr |=> !ctrl[TF0_BIT])
		else $error("timer 0 flag not cleared on vector");

	gate_blocks_a: assert property (
		mode_reg[GATE_BIT] && !active[0] && !lane_bus[0].wr_low && !lane_bus[0].wr_high
			|=> $stable(lane_low[0]))
		else $error("gated timer 0 counted with input inactive");

	level_mirror_a: assert property (
		!ctrl[IT0_BIT] && !ctrl_wr |=> ctrl[IE0_BIT] == $past(active[0]))
		else $error("level flag does not mirror input");

	edge_set_a: assert property (
		ctrl[IT0_BIT] && rise[0] |=> ctrl[IE0_BIT])
		else $error("edge flag not set on active edge");

	edge_vector_clear_a: assert property (
		ctrl[IT0_BIT] && ext_vector_ack_i[0] && !rise[0] && !ctrl_wr |=> !ctrl[IE0_BIT])
		else $error("edge flag not cleared on vector");

	pin_to_flag_a: assert property (
		ctrl[IT0_BIT] && !ctrl_wr && $rose(sync_b[0]) && pol[0] && $stable(pol[0])
			|=> ctrl[IE0_BIT])
		else $error("synchronised edge missed");

endmodule : dual_timer_top

// ---- verification/cpu_irq_model.sv ----
`timescale 1ns/1ps
// CPU side: vectors to every serviced request with a one-cycle acknowledge
module cpu_irq_model (
	// Clock and reset
	input  wire logic       clock_i,
	input  wire logic       reset_i,
	// Requests {ext1, ext0, timer1, timer0} and which of them are serviced
	input  wire logic [3:0] irq_i,
	input  wire logic [3:0] ack_en_i,
	// Vector acknowledges
	output logic      [3:0] ack_o
);
	logic [3:0] next_ack;

	// One pulse per request; the gap cycle lets the flag clear before a new pulse
	always_comb begin
		next_ack = irq_i & ack_en_i & ~ack_o;
	end

	// Launched off the falling edge so the design samples a settled pulse
	always_ff @(negedge clock_i) begin
		ack_o <= reset_i ? 4'h0 : next_ack;
	end
endmodule : cpu_irq_model

// ---- verification/dual_timer_with_ext_int_flags_bench.sv ----
`timescale 1ns/1ps
module dual_timer_with_ext_int_flags_bench;
	import timer_pkg::*;

	logic        clock_i   = 1'b0;
	logic        reset_i   = 1'b1;
	logic [7:0]  addr      = 8'h00;
	logic [7:0]  wdata     = 8'h00;
	logic        wr        = 1'b0;
	logic [1:0]  irq_en    = 2'h3;
	logic [1:0]  pin       = 2'h3;
	logic [3:0]  ack_en    = 4'h0;
	logic [31:0] seed      = 32'h28A59C04;
	logic [7:0]  rdata;
	logic [3:0]  ack;
	logic        t0_irq;
	logic        t1_irq;
	logic        x0_irq;
	logic        x1_irq;
	logic [7:0]  v;
	int          n;
	int          err_count = 0;
	int          cmp_count = 0;
	int          cycles    = 0;

	////////////////////////////////////////////////////////////////////////////
	dual_timer_top dut (
		.clock_i(clock_i), .reset_i(reset_i),
		.sfr_addr_i(addr), .sfr_wdata_i(wdata), .sfr_wr_i(wr), .sfr_rdata_o(rdata),
		.timer_irq_enable_i(irq_en), .timer_vector_ack_i(ack[1:0]),
		.ext_vector_ack_i(ack[3:2]), .timer0_irq_o(t0_irq), .timer1_irq_o(t1_irq),
		.ext_irq0_o(x0_irq), .ext_irq1_o(x1_irq),
		.ext_irq_input_0_i(pin[0]), .ext_irq_input_1_i(pin[1])
	);

	cpu_irq_model cpu (
		.clock_i(clock_i), .reset_i(reset_i),
		.irq_i({x1_irq, x0_irq, t1_irq, t0_irq}), .ack_en_i(ack_en), .ack_o(ack)
	);

	// 25 MHz system clock
	always #20 clock_i = ~clock_i;

	// Hang guard; the whole run needs under a thousand cycles
	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			report_and_stop();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xorshift

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// Bus tasks start and end at a falling edge; writes leave the strobe up so that
	// back-to-back writes never drop and raise it in one step; reads and ticks drop it
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clock_i);
	endtask : wr_reg

	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		wr = 1'b0;
		addr = a;
		@(negedge clock_i);
		d = rdata;
	endtask : rd_reg

	task automatic tick(input int k);
		wr = 1'b0;
		repeat (k) @(negedge clock_i);
	endtask : tick

	// 16-bit count across both bytes, flag, request and software clear
	task automatic run16(input int i);
		wr_reg(MODE_ADDR, 8'h11);
		wr_reg(LOW_ADDR[i], 8'hF0);
		wr_reg(HIGH_ADDR[i], 8'hFF);
		seed = xorshift(seed);
		irq_en = seed[1:0];
		wr_reg(CTRL_ADDR, 8'h10 << (2 * i));
		tick(30);
		rd_reg(CTRL_ADDR, v);
		check("flag set", v, 16'h30 << (2 * i));
		check("timer irq", i ? t1_irq : t0_irq, irq_en[i]);
		wr_reg(CTRL_ADDR, 8'h00);
		tick(5);
		rd_reg(CTRL_ADDR, v);
		check("flag cleared", v, 16'h0);
		rd_reg(LOW_ADDR[i], v);
		check("low byte", v, 16'h10);
		rd_reg(HIGH_ADDR[i], v);
		check("high byte", v, 16'h0);
	endtask : run16

	// Auto-reload periods measured from start to the first request, then between requests, CPU acknowledging each
	task automatic reload_run(input int i);
		logic [7:0] hi;
		logic [7:0] lo;
		seed = xorshift(seed);
		hi = 8'hC0 + seed[4:0];
		lo = 8'hE0 + seed[12:8];
		irq_en = 2'h3;
		ack_en = 4'h3;
		wr_reg(MODE_ADDR, 8'h22);
		wr_reg(HIGH_ADDR[i], hi);
		wr_reg(LOW_ADDR[i], lo);
		wr_reg(CTRL_ADDR, 8'h10 << (2 * i));
		wr = 1'b0;
		for (int k = 0; k < 3; k++) begin
			n = 0;
			do begin
				@(negedge clock_i);
				n++;
			end while ((i ? t1_irq : t0_irq) !== 1'b1 && n < 300);
			check("period", n[15:0], 16'h100 - (k == 0 ? lo : hi));
		end
		wr_reg(CTRL_ADDR, 8'h00);
		ack_en = 4'h0;
		rd_reg(HIGH_ADDR[i], v);
		check("reload byte", v, hi);
	endtask : reload_run

	task automatic report_and_stop;
		if (err_count == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : report_and_stop

	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (12) @(negedge clock_i);
		reset_i = 1'b0;
		tick(1);
		check("ext idle", {x1_irq, x0_irq}, 16'h0);
		// Reset values, unmapped address last
		foreach (LOW_ADDR[j]) begin
			rd_reg(LOW_ADDR[j], v);
			check("low reset", v, 16'h0);
			rd_reg(HIGH_ADDR[j], v);
			check("high reset", v, 16'h0);
		end
		rd_reg(CTRL_ADDR, v);
		check("control reset", v, CTRL_RESET);
		rd_reg(MODE_ADDR, v);
		check("mode reset", v, MODE_RESET);
		rd_reg(8'h50, v);
		check("unmapped", v, 16'h0);
		for (int i = 0; i < 2; i++) begin
			run16(i);
		end
		for (int r = 0; r < 4; r++) begin
			reload_run(r % 2);
		end
		// Gated count: only the cycles with the input active are counted
		wr_reg(MODE_ADDR, 8'h09);
		wr_reg(EXT_CFG_ADDR, 8'h01);
		pin[0] = 1'b0;
		wr_reg(LOW_ADDR[0], 8'h00);
		wr_reg(HIGH_ADDR[0], 8'h00);
		wr_reg(CTRL_ADDR, 8'h10);
		tick(10);
		rd_reg(LOW_ADDR[0], v);
		check("gated hold", v, 16'h0);
		pin[0] = 1'b1;
		tick(20);
		pin[0] = 1'b0;
		tick(10);
		rd_reg(LOW_ADDR[0], v);
		check("gated count", v, 16'd20);
		wr_reg(CTRL_ADDR, 8'h00);
		// Level mode follows active-low pins; acknowledges are ignored
		wr_reg(EXT_CFG_ADDR, 8'h00);
		ack_en = 4'hC;
		pin = 2'b00;
		tick(4);
		check("level irq", {x1_irq, x0_irq}, 16'h3);
		rd_reg(CTRL_ADDR, v);
		check("level flags", v, 16'h0A);
		pin = 2'b11;
		tick(4);
		rd_reg(CTRL_ADDR, v);
		check("level drop", v, 16'h0);
		// Edge mode latches, vector clears one input, software the other
		ack_en = 4'h0;
		pin = 2'b00;
		tick(4);
		wr_reg(EXT_CFG_ADDR, 8'h03);
		rd_reg(EXT_CFG_ADDR, v);
		check("polarity", v, 16'h03);
		tick(3);
		wr_reg(CTRL_ADDR, 8'h05);
		rd_reg(CTRL_ADDR, v);
		check("edge idle", v, 16'h05);
		pin = 2'b11;
		tick(4);
		pin = 2'b00;
		tick(4);
		rd_reg(CTRL_ADDR, v);
		check("edge latched", v, 16'h0F);
		ack_en = 4'h4;
		tick(3);
		ack_en = 4'h0;
		rd_reg(CTRL_ADDR, v);
		check("vector clear", v, 16'h0D);
		wr_reg(CTRL_ADDR, 8'h05);
		rd_reg(CTRL_ADDR, v);
		check("software clear", v, 16'h05);
		report_and_stop();
	end
endmodule : dual_timer_with_ext_int_flags_bench
